// >>> core_src_model.sv
// Model of the core, timer and pins that face the interrupt unit
`timescale 1ns/1ps
`default_nettype none
module core_src_model (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  // Requests from the bench
  input  wire logic       tmr_kick,
  input  wire logic       sleep_go,
  input  wire logic [7:0] pins_want,
  // Unit side
  input  wire logic       wake_req,
  output logic            timer_overflow,
  output logic [7:0]      second_io_port,
  output logic            core_sleeping,
  output logic            woke
);
  // Timer overflow as a one-cycle pulse
  always_ff @(posedge core_clk)
  begin
    timer_overflow <= tmr_kick & ~sys_rst;
  end

  // Pins follow the requested levels a cycle late
  always_ff @(posedge core_clk)
  begin
    second_io_port <= pins_want;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      core_sleeping <= 1'b0;
      woke          <= 1'b0;
    end
    else if (sleep_go)
    begin
      core_sleeping <= 1'b1;
      woke          <= 1'b0;
    end
    else if (core_sleeping && wake_req)
    begin
      core_sleeping <= 1'b0;
      woke          <= 1'b1;
    end
  end
endmodule : core_src_model
`default_nettype wire

// >>> interrupt_enable_flag_unit.sv
// Interrupt enable and flag unit with Avalon-MM register access
`timescale 1ns/1ps
`default_nettype none
module interrupt_enable_flag_unit
  import irq_flag_pkg::*;
#(
  parameter int ADDR_W = 12
)(
  // Clock and resets
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  input  wire logic              por_rst,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [3:0]        byteenable,
  input  wire logic [31:0]       writedata,
  output logic      [31:0]       readdata,
  output logic                   waitrequest,
  // Interrupt sources
  input  wire logic              timer_overflow,
  input  wire logic [7:0]        second_io_port,
  input  wire logic              ext_edge_rising,
  input  wire logic              cmp_irq_flag,
  input  wire logic              cmp_irq_enable,
  // Core side
  input  wire logic              core_sleeping,
  output logic                   core_irq_req,
  output logic                   wake_req,
  output logic      [12:0]       irq_vector,
  // Event interrupt
  output logic                   evt_irq
);

  // ***********************************************************
  // Helpers
  // ***********************************************************
  // Address matches either bank of the control register
  function automatic logic is_ctl(input logic [ADDR_W-1:0] a);
    is_ctl = (a == ADDR_W'(CTL_ADDR_BANK0)) || (a == ADDR_W'(CTL_ADDR_BANK1));
  endfunction : is_ctl

  // Any enabled source pair, peripheral pair optional
  function automatic logic pair_hit(input ctl_s c, input logic periph);
    pair_hit = (c.timer_overflow_irq_enable && c.timer_overflow_flag)
            || (c.ext_pin_irq_enable && c.ext_pin_irq_flag)
            || (c.port_change_irq_enable && c.port_change_flag)
            || periph;
  endfunction : pair_hit

  // ***********************************************************
  // Declarations
  // ***********************************************************
  ctl_s        ctl_reg;         // Interrupt control register
  evt_s        evt_stat_reg;    // Sticky event status
  evt_s        evt_mask_reg;    // Event mask
  logic [31:0] rdata_reg;       // Read data holding flop
  logic        wait_reg;        // Waitrequest flop
  logic        irq_reg;         // Core request flop
  logic        wake_reg;        // Wake request flop
  logic [12:0] vec_reg;         // Vector output flop
  logic        evt_irq_reg;     // Event interrupt flop
  logic        irq_prev_reg;    // Core request one cycle ago
  logic [4:0]  pin_sel;         // Pins watched by the filter
  logic [4:0]  pin_level;       // Filtered pin levels
  logic [4:0]  pin_chg;         // Filtered change pulses
  logic        bus_req;         // Read or write present
  logic        bus_acc;         // Access completes this edge
  logic        wr_ctl;          // Control register write
  logic        wr_stat;         // Status write one to clear
  logic        wr_mask;         // Mask write
  logic        ext_evt;         // External pin event
  logic        port_evt;        // Upper port change event
  logic        periph_pair;     // Gated comparator pair
  logic        any_pair;        // Any enabled pair incl. peripheral
  logic        irq_next;        // Next core request
  evt_s        evt_set;         // Event set strobes

  // ***********************************************************
  // Pin filtering
  // ***********************************************************
  // Bit zero plus bits seven to four only
  // change bits select
  assign pin_sel = {second_io_port[CHG_PIN_HI:CHG_PIN_LO], second_io_port[EXT_PIN_BIT]};

  // Synchronise and detect agreed changes
  pin_sync_filter #(
    .WIDTH     (5)
  ) u_pins (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .pin_in    (pin_sel),
    .level_reg (pin_level),
    .chg_reg   (pin_chg)
  );

  assign ext_evt  = pin_chg[0] && (pin_level[0] == ext_edge_rising);
  assign port_evt = |pin_chg[4:1];

  // ***********************************************************
  // Bus decode
  // ***********************************************************
  assign bus_req = read || write;
  assign bus_acc = bus_req && !wait_reg;
  assign wr_ctl  = bus_acc && write && byteenable[0] && is_ctl(address);
  assign wr_stat = bus_acc && write && byteenable[0] && (address == ADDR_W'(EVT_STAT_ADDR));
  assign wr_mask = bus_acc && write && byteenable[0] && (address == ADDR_W'(EVT_MASK_ADDR));

  // Waitrequest low for one cycle after a request is seen
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      wait_reg <= 1'b1;
    end
    else if (bus_req && wait_reg)
    begin
      wait_reg <= 1'b0;
    end
    else
    begin
      wait_reg <= 1'b1;
    end
  end

  // Read data captured while waitrequest is high
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      rdata_reg <= 32'h00000000;
    end
    else if (read && wait_reg)
    begin
      if (is_ctl(address))
      begin
        rdata_reg <= {24'h000000, ctl_reg};
      end
      else if (address == ADDR_W'(EVT_STAT_ADDR))
      begin
        rdata_reg <= {27'h0000000, evt_stat_reg};
      end
      else if (address == ADDR_W'(EVT_MASK_ADDR))
      begin
        rdata_reg <= {27'h0000000, evt_mask_reg};
      end
      else
      begin
        // Unmapped reads return zero
        rdata_reg <= 32'h00000000;
      end
    end
  end

  // ***********************************************************
  // Control register
  // ***********************************************************
  // Software write first, hardware sets win afterwards
  always_ff @(posedge core_clk)
  begin
    if (por_rst)
    begin
      ctl_reg <= CTL_RST;
    end
    else if (sys_rst)
    begin
      ctl_reg <= {7'h00, ctl_reg.port_change_flag};
    end
    else
    begin
      // Plain store of every bit
      if (wr_ctl)
      begin
        ctl_reg <= writedata[7:0];
      end
      if (timer_overflow)
      begin
        ctl_reg.timer_overflow_flag <= 1'b1;
      end
      if (ext_evt)
      begin
        ctl_reg.ext_pin_irq_flag <= 1'b1;
      end
      if (port_evt)
      begin
        ctl_reg.port_change_flag <= 1'b1;
      end
    end
  end

  // ***********************************************************
  // Request and wake
  // ***********************************************************
  // peripheral gate
  assign periph_pair = ctl_reg.peripheral_irq_enable && cmp_irq_flag && cmp_irq_enable;
  assign any_pair    = pair_hit(ctl_reg, periph_pair);
  assign irq_next    = ctl_reg.global_irq_enable && any_pair;

  // Core request and branch vector
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || por_rst)
    begin
      irq_reg      <= 1'b0;
      irq_prev_reg <= 1'b0;
      vec_reg      <= VECTOR_IDLE;
    end
    else
    begin
      irq_reg      <= irq_next;
      irq_prev_reg <= irq_reg;
      vec_reg      <= irq_next ? VECTOR_ADDR : VECTOR_IDLE;
    end
  end

  // Wake ignores the global enable
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || por_rst)
    begin
      wake_reg <= 1'b0;
    end
    else
    begin
      wake_reg <= core_sleeping && any_pair;
    end
  end

  // ***********************************************************
  // Event status, mask and interrupt
  // ***********************************************************
  assign evt_set = '{irq_raised:  irq_next && !irq_reg,
                     wake:        core_sleeping && any_pair && !wake_reg,
                     timer:       timer_overflow,
                     ext_pin:     ext_evt,
                     port_change: port_evt};

  // Write one to clear, set wins
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || por_rst)
    begin
      evt_stat_reg <= EVT_RST;
    end
    else
    begin
      evt_stat_reg <= (evt_stat_reg & ~(wr_stat ? writedata[4:0] : 5'h00)) | evt_set;
    end
  end

  // Mask register
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || por_rst)
    begin
      evt_mask_reg <= EVT_RST;
    end
    else if (wr_mask)
    begin
      evt_mask_reg <= writedata[4:0];
    end
  end

  // Level interrupt from unmasked status
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || por_rst)
    begin
      evt_irq_reg <= 1'b0;
    end
    else
    begin
      evt_irq_reg <= |(evt_stat_reg & evt_mask_reg);
    end
  end

  // ***********************************************************
  // Outputs
  // ***********************************************************
  assign readdata     = rdata_reg;
  assign waitrequest  = wait_reg;
  assign core_irq_req = irq_reg;
  assign wake_req     = wake_reg;
  assign irq_vector   = vec_reg;
  assign evt_irq      = evt_irq_reg;

  // ***********************************************************
  // Checks
  // ***********************************************************
  a_bus_one_wait: assert property (@(posedge core_clk) disable iff (sys_rst || por_rst)
    bus_req && wait_reg |=> !wait_reg ##1 wait_reg)
    else $error("waitrequest not low for exactly one cycle");

  a_flag_any_enable: assert property (@(posedge core_clk) disable iff (sys_rst || por_rst)
    timer_overflow && !ctl_reg.global_irq_enable |=> ctl_reg.timer_overflow_flag)
    else $error("flag not set with enables clear");

  a_global_blocks: assert property (@(posedge core_clk) disable iff (sys_rst || por_rst)
    !ctl_reg.global_irq_enable |=> !irq_reg)
    else $error("request passed with global enable clear");

  a_periph_gate: assert property (@(posedge core_clk) disable iff (sys_rst || por_rst)
    ctl_reg.global_irq_enable && cmp_irq_flag && cmp_irq_enable
    && !ctl_reg.peripheral_irq_enable && !pair_hit(ctl_reg, 1'b0) |=> !irq_reg)
    else $error("peripheral request passed while gated");

  a_timer_sticky: assert property (@(posedge core_clk) disable iff (sys_rst || por_rst)
    ctl_reg.timer_overflow_flag && !wr_ctl |=> ctl_reg.timer_overflow_flag)
    else $error("timer flag dropped without software");

  a_ext_flag_set: assert property (@(posedge core_clk) disable iff (sys_rst || por_rst)
    ext_evt |=> ctl_reg.ext_pin_irq_flag && evt_stat_reg.ext_pin)
    else $error("external event lost");

  a_port_flag_set: assert property (@(posedge core_clk) disable iff (sys_rst || por_rst)
    port_evt |=> ctl_reg.port_change_flag)
    else $error("port change lost");

  a_reset_clears: assert property (@(posedge core_clk) disable iff (por_rst)
    sys_rst |=> ctl_reg[7:1] == 7'h00 && ctl_reg.port_change_flag == $past(ctl_reg.port_change_flag))
    else $error("reset value of control register wrong");

  a_wake_pair: assert property (@(posedge core_clk) disable iff (sys_rst || por_rst)
    core_sleeping && any_pair |=> wake_reg)
    else $error("no wake for enabled pair");

  a_vector_fixed: assert property (@(posedge core_clk) disable iff (sys_rst || por_rst)
    irq_reg |-> vec_reg == VECTOR_ADDR)
    else $error("vector not fixed address");

  a_request_pair: assert property (@(posedge core_clk) disable iff (sys_rst || por_rst)
    !sys_rst && !por_rst |=> irq_reg == $past(ctl_reg.global_irq_enable
      && ((ctl_reg.timer_overflow_irq_enable && ctl_reg.timer_overflow_flag)
      || (ctl_reg.ext_pin_irq_enable && ctl_reg.ext_pin_irq_flag)
      || (ctl_reg.port_change_irq_enable && ctl_reg.port_change_flag)
      || (ctl_reg.peripheral_irq_enable && cmp_irq_flag && cmp_irq_enable))))
    else $error("core request does not follow pair");

  a_evt_irq_level: assert property (@(posedge core_clk) disable iff (sys_rst || por_rst)
    |(evt_stat_reg & evt_mask_reg) |=> evt_irq_reg)
    else $error("event interrupt not raised");

endmodule : interrupt_enable_flag_unit
`default_nettype wire

// >>> irq_flag_pkg.sv
// Constants, field layouts and carriers for the interrupt enable and flag unit
package irq_flag_pkg;

  // ***********************************************************
  // Register map
  // ***********************************************************
  // Printed register indices, one per bank
  localparam logic [7:0]  CTL_IDX_BANK0 = 8'h0B;
  localparam logic [7:0]  CTL_IDX_BANK1 = 8'h8B;
  // Avalon byte addresses, four times the index
  localparam logic [11:0] CTL_ADDR_BANK0 = 12'(CTL_IDX_BANK0) << 2;
  localparam logic [11:0] CTL_ADDR_BANK1 = 12'(CTL_IDX_BANK1) << 2;
  // Event status and mask registers
  localparam logic [11:0] EVT_STAT_ADDR = 12'h400;
  localparam logic [11:0] EVT_MASK_ADDR = 12'h404;

  // ***********************************************************
  // Reset values and request vector
  // ***********************************************************
  localparam logic [7:0]  CTL_RST      = 8'h00;
  localparam logic [4:0]  EVT_RST      = 5'h00;
  localparam logic [12:0] VECTOR_ADDR  = 13'h0004;
  localparam logic [12:0] VECTOR_IDLE  = 13'h0000;

  // ***********************************************************
  // Port bit positions
  // ***********************************************************
  localparam int EXT_PIN_BIT  = 0;
  localparam int CHG_PIN_LO   = 4;
  localparam int CHG_PIN_HI   = 7;
  // Synchroniser stages before agreement check
  localparam int SYNC_STAGES  = 3;

  // Interrupt control register layout, bit 7 first
  typedef struct packed {
    logic global_irq_enable;
    logic peripheral_irq_enable;
    logic timer_overflow_irq_enable;
    logic ext_pin_irq_enable;
    logic port_change_irq_enable;
    logic timer_overflow_flag;
    logic ext_pin_irq_flag;
    logic port_change_flag;
  } ctl_s;

  // Sticky event layout for status and mask
  typedef struct packed {
    logic irq_raised;
    logic wake;
    logic timer;
    logic ext_pin;
    logic port_change;
  } evt_s;

endpackage : irq_flag_pkg

// >>> pin_sync_filter.sv
// Three-stage pin synchroniser with agreement check and change pulse
`timescale 1ns/1ps
`default_nettype none
module pin_sync_filter
  import irq_flag_pkg::*;
#(
  parameter int WIDTH = 5
)(
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  // Asynchronous pins
  input  wire logic [WIDTH-1:0] pin_in,
  // Filtered level and change pulse
  output logic      [WIDTH-1:0] level_reg,
  output logic      [WIDTH-1:0] chg_reg
);

  // Synchroniser chain, stage 0 feeds only stage 1
  logic [WIDTH-1:0] sync_reg [SYNC_STAGES];

  // ***********************************************************
  // Chain
  // ***********************************************************
  // Shift pins through three flops
  always_ff @(posedge core_clk)
  begin
    sync_reg[0] <= pin_in;
    for (int i = 1; i < SYNC_STAGES; i++)
    begin
      sync_reg[i] <= sync_reg[i-1];
    end
  end

  // ***********************************************************
  // Agreement and change
  // ***********************************************************
  // Accept a new level once stages two and three agree
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      level_reg <= '0;
      chg_reg   <= '0;
    end
    else
    begin
      for (int b = 0; b < WIDTH; b++)
      begin
        // Bit is taken only on agreement
        if (sync_reg[1][b] == sync_reg[2][b])
        begin
          level_reg[b] <= sync_reg[2][b];
          chg_reg[b]   <= sync_reg[2][b] != level_reg[b];
        end
        else
        begin
          chg_reg[b] <= 1'b0;
        end
      end
    end
  end

  // Change pulse always carries the new level
  a_chg_new_level: assert property (@(posedge core_clk) disable iff (sys_rst)
    |chg_reg |-> level_reg != $past(level_reg))
    else $error("change pulse without level change");

endmodule : pin_sync_filter
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the interrupt enable and flag unit
`timescale 1ns/1ps
`default_nettype none
module tb;
  import irq_flag_pkg::*;
  // ********************
  // Signals
  // ********************
  logic        core_clk = 0, sys_rst = 1, por_rst = 1;
  logic [11:0] address = '0;
  logic        read = 0, write = 0;
  logic [3:0]  byteenable = '0;
  logic [31:0] writedata = '0, readdata, rd;
  logic        waitrequest, ext_edge_rising = 1, cmp_irq_flag = 0, cmp_irq_enable = 0;
  logic        tmr_kick = 0, sleep_go = 0, timer_overflow, core_sleeping, woke;
  logic [7:0]  pins_want = '0, second_io_port;
  logic        core_irq_req, wake_req, evt_irq;
  logic [12:0] irq_vector;
  logic [31:0] lfsr_state = 32'h32BC6B5B;
  ctl_s        c;
  int          num_errors = 0, checks = 0;

  // Half period of 2.5 ns gives 200 MHz
  always #2.5 core_clk = ~core_clk;

  interrupt_enable_flag_unit interrupt_enable_flag_unit_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .por_rst(por_rst), .address(address),
    .read(read), .write(write), .byteenable(byteenable), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .timer_overflow(timer_overflow),
    .second_io_port(second_io_port), .ext_edge_rising(ext_edge_rising),
    .cmp_irq_flag(cmp_irq_flag), .cmp_irq_enable(cmp_irq_enable),
    .core_sleeping(core_sleeping), .core_irq_req(core_irq_req), .wake_req(wake_req),
    .irq_vector(irq_vector), .evt_irq(evt_irq));

  core_src_model core_src_model_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .tmr_kick(tmr_kick), .sleep_go(sleep_go),
    .pins_want(pins_want), .wake_req(wake_req), .timer_overflow(timer_overflow),
    .second_io_port(second_io_port), .core_sleeping(core_sleeping), .woke(woke));

  // ********************
  // Expectation helpers
  // ********************
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  // Core request from the register, comparator gated by peripheral enable
  function automatic logic exp_req(input ctl_s r, input logic cf, input logic ce);
    return r.global_irq_enable & ((r.timer_overflow_irq_enable & r.timer_overflow_flag)
      | (r.ext_pin_irq_enable & r.ext_pin_irq_flag)
      | (r.port_change_irq_enable & r.port_change_flag)
      | (r.peripheral_irq_enable & cf & ce));
  endfunction : exp_req

  // ********************
  // Compare and bus tasks
  // ********************
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: bit %b, expected %b", $time, got, exp);
    end
  endtask : chk_bit

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick

  // Holds the request until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [11:0] a, input logic [3:0] be,
                     input logic [31:0] wd);
    address <= a;
    write <= wr;
    read <= ~wr;
    byteenable <= be;
    writedata <= wd;
    // Only the watchdog ends a wait that never gets an answer
    do
    begin
      @(posedge core_clk);
    end
    while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge core_clk);
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    bus(1'b1, a, 4'hF, {24'h0, d});
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic [7:0] e);
    bus(1'b0, a, 4'hF, 32'h0);
    chk_word(rd, {24'h0, e});
  endtask : rdc

  task automatic kick();
    tmr_kick <= 1'b1;
    tick(1);
    tmr_kick <= 1'b0;
  endtask : kick

  task automatic conclude();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude

  // Watchdog against a hung handshake
  initial
  begin
    tick(20000);
    num_errors++;
    conclude();
  end

  // ********************
  // Main sequence
  // ********************
  initial
  begin
    tick(4);
    sys_rst <= 1'b0;
    por_rst <= 1'b0;
    tick(1);
    rdc(CTL_ADDR_BANK0, 8'h00);
    rdc(12'h100, 8'h00);
    // Random enables written at one bank, read at the other
    for (int i = 0; i < 6; i++)
    begin
      lfsr_state = lfsr_next(lfsr_state);
      wr(i[0] ? CTL_ADDR_BANK1 : CTL_ADDR_BANK0, {lfsr_state[7:3], 3'b000});
      rdc(i[0] ? CTL_ADDR_BANK0 : CTL_ADDR_BANK1, {lfsr_state[7:3], 3'b000});
    end
    bus(1'b1, CTL_ADDR_BANK0, 4'h0, 32'hFF);
    rdc(CTL_ADDR_BANK1, {lfsr_state[7:3], 3'b000});
    // Timer flag with every enable clear
    wr(CTL_ADDR_BANK0, 8'h00);
    kick();
    tick(4);
    chk_bit(core_irq_req, 1'b0);
    rdc(CTL_ADDR_BANK0, 8'h04);
    wr(CTL_ADDR_BANK0, 8'hA4);
    tick(10);
    chk_bit(core_irq_req, 1'b1);
    chk_word({19'h0, irq_vector}, {19'h0, VECTOR_ADDR});
    rdc(CTL_ADDR_BANK1, 8'hA4);
    wr(CTL_ADDR_BANK0, 8'hA0);
    tick(3);
    chk_bit(core_irq_req, 1'b0);
    chk_word({19'h0, irq_vector}, {19'h0, VECTOR_IDLE});
    // Bits three to one never flag, bit zero does
    wr(CTL_ADDR_BANK0, 8'h00);
    lfsr_state = lfsr_next(lfsr_state);
    pins_want <= {4'h0, lfsr_state[2:0] | 3'b100, 1'b0};
    tick(10);
    rdc(CTL_ADDR_BANK0, 8'h00);
    pins_want[0] <= 1'b1;
    tick(10);
    rdc(CTL_ADDR_BANK0, 8'h02);
    wr(CTL_ADDR_BANK0, 8'h00);
    rdc(CTL_ADDR_BANK0, 8'h00);
    // Each upper pin flags a change
    for (int k = 4; k < 8; k++)
    begin
      pins_want[k] <= 1'b1;
      tick(10);
      rdc(CTL_ADDR_BANK0, 8'h01);
      wr(CTL_ADDR_BANK0, 8'h00);
    end
    // Falling edge on bit zero counts in falling mode
    ext_edge_rising <= 1'b0;
    pins_want[0] <= 1'b0;
    tick(10);
    rdc(CTL_ADDR_BANK0, 8'h02);
    wr(CTL_ADDR_BANK0, 8'h00);
    ext_edge_rising <= 1'b1;
    // Wake from sleep with the global enable clear
    pins_want <= 8'h00;
    tick(10);
    wr(CTL_ADDR_BANK0, 8'h10);
    sleep_go <= 1'b1;
    tick(1);
    sleep_go <= 1'b0;
    tick(5);
    chk_bit(woke, 1'b0);
    pins_want[0] <= 1'b1;
    tick(10);
    chk_bit(woke, 1'b1);
    chk_bit(core_irq_req, 1'b0);
    sleep_go <= 1'b1;
    tick(1);
    sleep_go <= 1'b0;
    tick(5);
    chk_bit(woke, 1'b1);
    // Comparator request through both gates
    cmp_irq_enable <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      c = ctl_s'({i[0], i[1], 6'h00});
      cmp_irq_flag <= i[2];
      wr(CTL_ADDR_BANK0, c);
      tick(3);
      chk_bit(core_irq_req, exp_req(c, i[2], 1'b1));
    end
    cmp_irq_flag <= 1'b0;
    // Device reset keeps the change flag, power-on clears it
    pins_want <= 8'h00;
    tick(10);
    pins_want <= 8'h10;
    tick(10);
    pins_want <= 8'h00;
    tick(10);
    wr(CTL_ADDR_BANK0, 8'hF9);
    sys_rst <= 1'b1;
    tick(3);
    sys_rst <= 1'b0;
    tick(1);
    rdc(CTL_ADDR_BANK0, 8'h01);
    por_rst <= 1'b1;
    tick(1);
    por_rst <= 1'b0;
    tick(1);
    rdc(CTL_ADDR_BANK0, 8'h00);
    // Event interrupt raised, cleared, then masked
    wr(EVT_MASK_ADDR, 8'h04);
    kick();
    tick(4);
    chk_bit(evt_irq, 1'b1);
    rdc(EVT_STAT_ADDR, 8'h04);
    wr(EVT_STAT_ADDR, 8'h1F);
    tick(3);
    chk_bit(evt_irq, 1'b0);
    wr(EVT_MASK_ADDR, 8'h00);
    kick();
    tick(4);
    chk_bit(evt_irq, 1'b0);
    conclude();
  end
endmodule : tb
`default_nettype wire
